// [rtl/qicr_device.sv]
// device end: quad-lane transfers with continuous read and burst wrap
//
// Overview of operation
// - command on lane 0, then four lanes
// - address: six clocks, four bits each
// - reads: device drives four lanes after address
// - write-type transfers: lanes stay device inputs
// - host drives mode byte 20h to keep continuous mode
// - host sends FFh otherwise
// - dummy clocks precede read data
// - continuous mode needs both enable bits
// - only two read commands allow continuous mode
// - aligned variant forces doubleword-aligned address
// - mode bits 5:4 equal 10 enter
// - continuous transfers carry address and mode only
// - chip select high suspends output
// - other mode bits leave continuous mode
// - command-less transfers run the continuous reads
// - wrap command bits 6:4 set length
// - wrap sizes 8/16/32/64 for continuous reads
// - host leaves continuous mode before wrap change
// - wrap command uses single-lane command phase
// - sample rising serial edge, drive falling
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module qicr_device import qicr_pkg::*; #(
	parameter int DUMMY_CLKS = QICR_DUMMY_CLKS
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	qicr_link_if.device link,
	input wire logic i_quad_lane_enable_bit,
	input wire logic i_continuous_read_enable,
	input wire logic [7:0] i_rd_data,
	output logic [23:0] o_rd_addr,
	output logic o_rd_strobe,
	output logic o_continuous_mode,
	output logic [2:0] o_wrap_bits
);
	if (DUMMY_CLKS < 1 || DUMMY_CLKS > 255) begin : g_chk
		$error("qicr_device: DUMMY_CLKS out of range");
	end

	typedef struct packed {
		qicr_dev_st_t st;
		logic [7:0] cnt;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic [7:0] mode;
		logic [7:0] wbyte;
		logic cont;
		logic [2:0] wrap;
		logic nib;
		logic [3:0] dout;
		logic [3:0] doe;
		logic rd_stb;
		logic [2:0] sclk_s;
		logic [1:0] cs_s;
		logic [3:0] io_s1;
		logic [3:0] io_s2;
	} qicr_dev_state_t;

	qicr_dev_state_t r_reg;
	qicr_dev_state_t r_next;

	function automatic logic is_cont_cmd(input logic [7:0] c);
		is_cont_cmd = (c == QICR_CMD_READ_CONT) || (c == QICR_CMD_READ_CONT_DWA);
	endfunction

	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [2:0] w,
		input logic [7:0] c);
		logic [6:0] span;
		logic [5:0] m;
		logic [5:0] inc;
		span = QICR_WRAP_MIN << w[2:1];
		m = 6'(span - 7'h01);
		inc = a[5:0] + 6'h01;
		if (!w[QICR_WRAP_OFF_BIT] && is_cont_cmd(c)) begin
			next_addr = {a[23:6], (a[5:0] & ~m) | (inc & m)};
		end else begin
			next_addr = a + 24'h000001;
		end
	endfunction

	logic rise;
	logic fall;
	logic [3:0] nib_in;
	logic [7:0] mode_new;
	logic [23:0] addr_new;
	logic [7:0] wbyte_new;

	always_comb begin
		r_next = r_reg;
		r_next.sclk_s = {r_reg.sclk_s[1:0], link.sclk};
		r_next.cs_s = {r_reg.cs_s[0], link.cs_n};
		r_next.io_s1 = link.io;
		r_next.io_s2 = r_reg.io_s1;
		r_next.rd_stb = 1'b0;
		// edges of the synchronised serial clock
		rise = r_reg.sclk_s[1] & ~r_reg.sclk_s[2];
		fall = ~r_reg.sclk_s[1] & r_reg.sclk_s[2];
		nib_in = r_reg.io_s2;
		mode_new = {r_reg.mode[3:0], nib_in};
		addr_new = {r_reg.addr[19:0], nib_in};
		wbyte_new = {r_reg.wbyte[3:0], nib_in};
		if (r_reg.cs_s[1]) begin
			r_next.st = DS_IDLE;
			r_next.doe = 4'h0;
			r_next.cnt = 8'h00;
			r_next.nib = 1'b0;
		end else begin
			unique case (r_reg.st)
				DS_IDLE: begin
					r_next.cnt = 8'h00;
					// continuous mode skips the command phase
					if (r_reg.cont) begin
						r_next.st = DS_ADDR;
					end else begin
						r_next.st = DS_CMD;
					end
				end
				DS_CMD: if (rise) begin
					r_next.cmd = {r_reg.cmd[6:0], nib_in[0]};
					r_next.cnt = r_reg.cnt + 8'h01;
					if (r_reg.cnt == 8'(QICR_CMD_CLKS - 1)) begin
						r_next.cnt = 8'h00;
						if (i_quad_lane_enable_bit && (is_cont_cmd(r_next.cmd) ||
							r_next.cmd == QICR_CMD_READ_ID ||
							r_next.cmd == QICR_CMD_SET_WRAP)) begin
							r_next.st = DS_ADDR;
						end else begin
							r_next.st = DS_SKIP;
						end
					end
				end
				DS_ADDR: if (rise) begin
					// high nibble first, lane 3 is msb
					r_next.addr = addr_new;
					r_next.cnt = r_reg.cnt + 8'h01;
					if (r_reg.cnt == 8'(QICR_ADDR_CLKS - 1)) begin
						r_next.cnt = 8'h00;
						// aligned variant drops low address bits
						if (r_reg.cmd == QICR_CMD_READ_CONT_DWA) begin
							r_next.addr[1:0] = QICR_DWA_ZERO;
						end
						// write-type transfer keeps lanes as inputs
						if (r_reg.cmd == QICR_CMD_SET_WRAP) begin
							r_next.st = DS_WDATA;
						end else begin
							r_next.st = DS_MODE;
						end
					end
				end
				DS_MODE: if (rise) begin
					r_next.mode = mode_new;
					r_next.cnt = r_reg.cnt + 8'h01;
					if (r_reg.cnt == 8'(QICR_MODE_CLKS - 1)) begin
						r_next.cnt = 8'h00;
						r_next.st = DS_DUMMY;
						// only the two continuous reads qualify
						// mode bits 10 enter continuous mode
						// command-less transfers reuse the held command
						r_next.cont = i_quad_lane_enable_bit && i_continuous_read_enable &&
							is_cont_cmd(r_reg.cmd) &&
							(mode_new[QICR_MODE_HI:QICR_MODE_LO] == QICR_MODE_CONT);
					end
				end
				DS_DUMMY: if (rise) begin
					r_next.cnt = r_reg.cnt + 8'h01;
					if (r_reg.cnt == 8'(DUMMY_CLKS - 1)) begin
						r_next.cnt = 8'h00;
						r_next.nib = 1'b0;
						r_next.st = DS_RDATA;
					end
				end
				DS_RDATA: if (fall) begin
					// four lanes driven on each falling edge
					r_next.doe = 4'hf;
					r_next.nib = ~r_reg.nib;
					if (r_reg.nib) begin
						r_next.dout = i_rd_data[3:0];
						// wrap applies inside the selected section
						r_next.addr = next_addr(r_reg.addr, r_reg.wrap, r_reg.cmd);
						r_next.rd_stb = 1'b1;
					end else begin
						r_next.dout = i_rd_data[7:4];
					end
				end
				DS_WDATA: if (rise) begin
					r_next.wbyte = wbyte_new;
					r_next.nib = ~r_reg.nib;
					// wrap length from data bits 6:4
					// wrap command arrives as a 1-4-4 transfer
					if (r_reg.nib) begin
						r_next.wrap = wbyte_new[QICR_WRAP_HI:QICR_WRAP_LO];
					end
				end
				DS_SKIP: begin
					r_next.doe = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r_reg <= '0;
			r_reg.wrap <= QICR_WRAP_RESET;
			r_reg.cs_s <= '1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.dev_out = r_reg.dout;
	assign link.dev_oe = r_reg.doe;
	assign o_rd_addr = r_reg.addr;
	assign o_rd_strobe = r_reg.rd_stb;
	assign o_continuous_mode = r_reg.cont;
	assign o_wrap_bits = r_reg.wrap;
endmodule

// [rtl/qicr_pkg.sv]
// shared constants and state codes for the quad-lane continuous read link
package qicr_pkg;
	localparam int QICR_ADDR_W = 24;
	localparam int QICR_CMD_CLKS = 8;
	localparam int QICR_ADDR_CLKS = 6;
	localparam int QICR_MODE_CLKS = 2;
	localparam int QICR_DUMMY_CLKS = 4;
	localparam int QICR_SYS_CLK_NS = 40;
	localparam int QICR_SCLK_PERIOD_NS = 320;
	localparam int QICR_SCLK_HALF_CYC = QICR_SCLK_PERIOD_NS / (2 * QICR_SYS_CLK_NS);
	localparam int QICR_MIN_HALF_CYC = 4;
	localparam logic [7:0] QICR_CMD_READ_CONT = 8'heb;
	localparam logic [7:0] QICR_CMD_READ_CONT_DWA = 8'he7;
	localparam logic [7:0] QICR_CMD_READ_ID = 8'h94;
	localparam logic [7:0] QICR_CMD_SET_WRAP = 8'h77;
	localparam logic [1:0] QICR_MODE_CONT = 2'b10;
	localparam int QICR_MODE_HI = 5;
	localparam int QICR_MODE_LO = 4;
	localparam logic [7:0] QICR_MODE_STAY = 8'h20;
	localparam logic [7:0] QICR_MODE_LEAVE = 8'hff;
	localparam int QICR_WRAP_HI = 6;
	localparam int QICR_WRAP_LO = 4;
	localparam logic [2:0] QICR_WRAP_RESET = 3'h1;
	localparam int QICR_WRAP_OFF_BIT = 0;
	localparam logic [6:0] QICR_WRAP_MIN = 7'h08;
	localparam logic [1:0] QICR_DWA_ZERO = 2'h0;
	typedef enum logic [2:0] {
		DS_IDLE, DS_CMD, DS_ADDR, DS_MODE, DS_DUMMY, DS_RDATA, DS_WDATA, DS_SKIP
	} qicr_dev_st_t;
	typedef enum logic [2:0] {
		HS_IDLE, HS_CMD, HS_ADDR, HS_MODE, HS_DUMMY, HS_RDATA, HS_END
	} qicr_host_st_t;
endpackage

// [rtl/qicr_link_if.sv]
// four-lane serial link between host and device ends
`timescale 1ns/1ns
interface qicr_link_if;
	logic sclk;
	logic cs_n;
	logic [3:0] host_out;
	logic [3:0] host_oe;
	logic [3:0] dev_out;
	logic [3:0] dev_oe;
	logic [3:0] io;
	// wire level; undriven lanes pulled high
	assign io = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out) | (~dev_oe & ~host_oe);
	modport host (output sclk, output cs_n, output host_out, output host_oe, input io);
	modport device (input sclk, input cs_n, input io, output dev_out, output dev_oe);
endinterface

// [rtl/qicr_host.sv]
// host end: drives serial clock, chip select and quad-lane transfers
`timescale 1ns/1ns
module qicr_host import qicr_pkg::*; #(
	parameter int SCLK_HALF = QICR_SCLK_HALF_CYC,
	parameter int DUMMY_CLKS = QICR_DUMMY_CLKS
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	qicr_link_if.host link,
	input wire logic i_start,
	input wire logic i_skip_cmd,
	input wire logic [7:0] i_cmd,
	input wire logic [23:0] i_addr,
	input wire logic i_keep_cont,
	input wire logic i_is_write,
	input wire logic [7:0] i_wr_data,
	input wire logic [7:0] i_rd_len,
	output logic o_busy,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid
);
	if (SCLK_HALF < QICR_MIN_HALF_CYC || SCLK_HALF > 255 || DUMMY_CLKS < 1 ||
		DUMMY_CLKS > 255) begin : g_chk
		$error("qicr_host: parameter out of range");
	end

	typedef struct packed {
		qicr_host_st_t st;
		logic [7:0] half;
		logic sclk;
		logic cs_n;
		logic [7:0] cnt;
		logic [7:0] csh;
		logic [31:0] sh;
		logic wr;
		logic [3:0] dout;
		logic [3:0] doe;
		logic [7:0] left;
		logic nib;
		logic [7:0] rbyte;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [3:0] io_s1;
		logic [3:0] io_s2;
	} qicr_host_state_t;

	qicr_host_state_t r_reg;
	qicr_host_state_t r_next;
	logic tick;
	logic [7:0] mode_byte;
	logic [31:0] sh_shift;

	always_comb begin
		r_next = r_reg;
		r_next.io_s1 = link.io;
		r_next.io_s2 = r_reg.io_s1;
		r_next.rd_valid = 1'b0;
		tick = r_reg.half == 8'(SCLK_HALF - 1);
		sh_shift = {r_reg.sh[27:0], 4'h0};
		// idle value when continuous mode is not wanted
		mode_byte = i_keep_cont ? QICR_MODE_STAY : QICR_MODE_LEAVE;
		if (r_reg.st != HS_IDLE) begin
			r_next.half = tick ? 8'h00 : r_reg.half + 8'h01;
		end
		unique case (r_reg.st)
			HS_IDLE: begin
				r_next.half = 8'h00;
				if (i_start) begin
					r_next.cs_n = 1'b0;
					r_next.cnt = 8'h00;
					r_next.wr = i_is_write;
					r_next.left = (i_rd_len == 8'h00) ? 8'h01 : i_rd_len;
					r_next.csh = i_cmd;
					r_next.sh = {i_addr, i_is_write ? i_wr_data : mode_byte};
					// a command-less transfer may carry the leave value
					if (i_skip_cmd) begin
						r_next.st = HS_ADDR;
						r_next.dout = i_addr[23:20];
						r_next.doe = 4'hf;
					end else begin
						// wrap command uses the same single-lane phase
						r_next.st = HS_CMD;
						r_next.dout = {3'h0, i_cmd[7]};
						r_next.doe = 4'h1;
					end
				end
			end
			HS_END: if (tick) begin
				r_next.cs_n = 1'b1;
				r_next.doe = 4'h0;
				r_next.st = HS_IDLE;
			end
			default: if (tick) begin
				// mode 0: outputs change while the clock falls
				r_next.sclk = ~r_reg.sclk;
				if (r_reg.sclk) begin
					r_next.cnt = r_reg.cnt + 8'h01;
					unique case (r_reg.st)
						HS_CMD: begin
							r_next.csh = {r_reg.csh[6:0], 1'b0};
							r_next.dout = {3'h0, r_reg.csh[6]};
							if (r_reg.cnt == 8'(QICR_CMD_CLKS - 1)) begin
								r_next.cnt = 8'h00;
								r_next.st = HS_ADDR;
								r_next.dout = r_reg.sh[31:28];
								r_next.doe = 4'hf;
							end
						end
						HS_ADDR: begin
							// msb nibble first, lane 3 msb
							r_next.sh = sh_shift;
							r_next.dout = sh_shift[31:28];
							if (r_reg.cnt == 8'(QICR_ADDR_CLKS - 1)) begin
								r_next.cnt = 8'h00;
								r_next.st = HS_MODE;
							end
						end
						HS_MODE: begin
							r_next.sh = sh_shift;
							r_next.dout = sh_shift[31:28];
							if (r_reg.cnt == 8'(QICR_MODE_CLKS - 1)) begin
								r_next.cnt = 8'h00;
								// write data went out on four lanes
								if (r_reg.wr) begin
									r_next.st = HS_END;
								end else begin
									r_next.st = HS_DUMMY;
									r_next.doe = 4'h0;
								end
							end
						end
						HS_DUMMY: begin
							if (r_reg.cnt == 8'(DUMMY_CLKS - 1)) begin
								r_next.cnt = 8'h00;
								r_next.nib = 1'b0;
								r_next.st = HS_RDATA;
							end
						end
						HS_RDATA: begin
							r_next.rbyte = {r_reg.rbyte[3:0], r_reg.io_s2};
							r_next.nib = ~r_reg.nib;
							if (r_reg.nib) begin
								r_next.rd_data = {r_reg.rbyte[3:0], r_reg.io_s2};
								r_next.rd_valid = 1'b1;
								r_next.left = r_reg.left - 8'h01;
								if (r_reg.left == 8'h01) begin
									r_next.st = HS_END;
								end
							end
						end
						default: begin
							r_next.st = HS_END;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r_reg <= '0;
			r_reg.cs_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.sclk = r_reg.sclk;
	assign link.cs_n = r_reg.cs_n;
	assign link.host_out = r_reg.dout;
	assign link.host_oe = r_reg.doe;
	assign o_busy = r_reg.st != HS_IDLE;
	assign o_rd_data = r_reg.rd_data;
	assign o_rd_valid = r_reg.rd_valid;
endmodule

// [verif/qicr_link_sva.sv]
// assertions on the quad-lane link between host and device ends
`timescale 1ns/1ns
module qicr_link_sva (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] host_out,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe
);
	logic sclk_reg;
	logic [7:0] edges_reg;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// serial rising edges since frame start
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sclk_reg <= 1'b0;
			edges_reg <= 8'h0;
		end else begin
			sclk_reg <= sclk;
			edges_reg <= cs_n ? 8'h0 : edges_reg + 8'(sclk && !sclk_reg);
		end
	end
	property p_no_fight;
		!(|(host_oe & dev_oe));
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("both ends drive a lane");
	property p_dev_all;
		dev_oe == 4'h0 || dev_oe == 4'hf;
	endproperty
	a_dev_all: assert property (p_dev_all)
		else $error("device lanes not turned together");
	property p_cmd_lane;
		$fell(cs_n) |-> host_oe == 4'h1 || host_oe == 4'hf;
	endproperty
	a_cmd_lane: assert property (p_cmd_lane)
		else $error("frame opens on wrong lanes");
	property p_idle_clk;
		cs_n |-> !sclk;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("serial clock high while deselected");
	property p_suspend;
		$rose(cs_n) |-> ##[1:4] dev_oe == 4'h0;
	endproperty
	a_suspend: assert property (p_suspend)
		else $error("device output not suspended");
	property p_dev_fall;
		dev_oe == 4'hf && $past(dev_oe) == 4'hf && $changed(dev_out) |-> !sclk || !$past(sclk);
	endproperty
	a_dev_fall: assert property (p_dev_fall)
		else $error("device data changed with clock high");
	property p_host_fall;
		!cs_n && $changed(host_out) |-> !sclk;
	endproperty
	a_host_fall: assert property (p_host_fall)
		else $error("host data changed with clock high");
	property p_turn;
		$rose(dev_oe[0]) |-> !cs_n && host_oe == 4'h0 && edges_reg >= 8'h0c && edges_reg <= 8'h14;
	endproperty
	a_turn: assert property (p_turn)
		else $error("device turned lanes at wrong count");
	property p_mode_driven;
		!cs_n && edges_reg < 8'h08 |-> host_oe != 4'h0;
	endproperty
	a_mode_driven: assert property (p_mode_driven)
		else $error("lanes left floating before dummy");
endmodule

// [verif/quad_io_continuous_read_test.sv]
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ns
module quad_io_continuous_read_test import qicr_pkg::*;;
	logic clk, arst_n, start, skip, keep, wr, qe, cre, busy, rvalid, rstb, cmode, dead;
	logic [7:0] cmd, wdata, len, rdata, cur;
	logic [23:0] addr, raddr;
	logic [2:0] wrap, ew;
	logic [31:0] seed, r;
	int num_errors, num_checks, cyc, i;
	qicr_link_if u_qicr_link_if ();
	qicr_host u_qicr_host (.i_sys_clk(clk), .i_arst_n(arst_n), .link(u_qicr_link_if),
		.i_start(start), .i_skip_cmd(skip), .i_cmd(cmd), .i_addr(addr), .i_keep_cont(keep),
		.i_is_write(wr), .i_wr_data(wdata), .i_rd_len(len), .o_busy(busy),
		.o_rd_data(rdata), .o_rd_valid(rvalid));
	qicr_device u_qicr_device (.i_sys_clk(clk), .i_arst_n(arst_n), .link(u_qicr_link_if),
		.i_quad_lane_enable_bit(qe), .i_continuous_read_enable(cre), .i_rd_data(mem(raddr)),
		.o_rd_addr(raddr), .o_rd_strobe(rstb), .o_continuous_mode(cmode), .o_wrap_bits(wrap));
	qicr_link_sva u_chk (.i_sys_clk(clk), .i_arst_n(arst_n), .sclk(u_qicr_link_if.sclk),
		.cs_n(u_qicr_link_if.cs_n), .host_out(u_qicr_link_if.host_out),
		.host_oe(u_qicr_link_if.host_oe), .dev_out(u_qicr_link_if.dev_out),
		.dev_oe(u_qicr_link_if.dev_oe));
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
	endfunction
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// address of byte k under the wrap setting
	function automatic logic [23:0] exp_addr(input logic [23:0] a, input int k);
		logic [23:0] m;
		logic wc;
		m = (24'h8 << ew[2:1]) - 24'h1;
		wc = cur == QICR_CMD_READ_CONT || cur == QICR_CMD_READ_CONT_DWA;
		if (!wc || ew[0]) return a + 24'(k);
		return (a & ~m) | ((a + 24'(k)) & m);
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one frame; n is byte count, or data byte when writing
	task automatic xfer(input logic sk, input logic [7:0] c, input logic [23:0] a,
		input logic kp, input logic w, input logic [7:0] n);
		int k;
		int got;
		int stb;
		logic oe_seen;
		logic [23:0] b;
		got = 0;
		stb = 0;
		oe_seen = 1'b0;
		if (!sk) cur = c;
		b = (cur == QICR_CMD_READ_CONT_DWA) ? {a[23:2], 2'b00} : a;
		@(posedge clk);
		start <= 1'b1;
		skip <= sk;
		cmd <= c;
		addr <= a;
		keep <= kp;
		wr <= w;
		wdata <= n;
		len <= n;
		@(posedge clk);
		start <= 1'b0;
		for (k = 0; k < 3000 && (k < 2 || busy); k++) begin
			@(posedge clk);
			if (u_qicr_link_if.dev_oe != 4'h0) oe_seen = 1'b1;
			if (rstb === 1'b1) stb++;
			if (rvalid === 1'b1) begin
				check(24'(rdata), dead ? 24'hff : 24'(mem(exp_addr(b, got))));
				got++;
			end
		end
		if (w) check(24'(oe_seen), 24'h0);
		else check(24'(got), 24'(n));
		check(24'(stb), (w || dead) ? 24'h0 : 24'(n));
		if (!w && !dead) check(raddr, exp_addr(b, int'(n)));
		repeat (4) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		{arst_n, start, skip, keep, wr, cmd, addr, wdata} = '0;
		{qe, cre, len, cur} = {1'b1, 1'b1, 8'h1, 8'h0};
		dead = 1'b0;
		seed = 32'h0000d36e;
		ew = 3'h1;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		check(24'(wrap), 24'(QICR_WRAP_RESET));
		r = rnd();
		xfer(1'b0, QICR_CMD_READ_ID, r[23:0], 1'b1, 1'b0, 8'h3);
		check(24'(cmode), 24'h0);
		cre <= 1'b0;
		r = rnd();
		xfer(1'b0, QICR_CMD_READ_CONT, r[23:0], 1'b1, 1'b0, 8'h2);
		check(24'(cmode), 24'h0);
		qe <= 1'b0;
		cre <= 1'b1;
		dead = 1'b1;
		r = rnd();
		xfer(1'b0, QICR_CMD_READ_CONT, r[23:0], 1'b1, 1'b0, 8'h2);
		check(24'(cmode), 24'h0);
		qe <= 1'b1;
		dead = 1'b0;
		cre <= 1'b1;
		r = rnd();
		xfer(1'b0, QICR_CMD_READ_CONT_DWA, r[23:0], 1'b1, 1'b0, 8'h4);
		check(24'(cmode), 24'h1);
		for (i = 0; i < 3; i++) begin
			r = rnd();
			xfer(1'b1, 8'h0, r[23:0], 1'b1, 1'b0, 8'(r[26:24]) + 8'h1);
			check(24'(cmode), 24'h1);
		end
		r = rnd();
		xfer(1'b1, 8'h0, r[23:0], 1'b0, 1'b0, 8'h2);
		check(24'(cmode), 24'h0);
		for (i = 0; i < 4; i++) begin
			r = rnd();
			xfer(1'b0, QICR_CMD_SET_WRAP, r[23:0], 1'b0, 1'b1, {1'b0, 2'(i), 5'h0});
			ew = {2'(i), 1'b0};
			check(24'(wrap), 24'(ew));
			r = rnd();
			cur = i[0] ? QICR_CMD_READ_CONT_DWA : QICR_CMD_READ_CONT;
			xfer(1'b0, cur, {r[23:6], 6'h3b}, i[1], 1'b0, 8'h9);
			if (i[1]) xfer(1'b1, 8'h0, r[23:0], 1'b0, 1'b0, 8'h3);
		end
		xfer(1'b0, QICR_CMD_SET_WRAP, 24'h0, 1'b0, 1'b1, 8'h10);
		ew = 3'h1;
		check(24'(wrap), 24'h1);
		r = rnd();
		xfer(1'b0, QICR_CMD_READ_CONT, {r[23:6], 6'h3b}, 1'b0, 1'b0, 8'h9);
		close_out();
	end
endmodule
